// File: bench/far_datapath_model.sv
module far_datapath_model (
  // clock and trigger
  input wire logic clk_in,
  input wire logic tick_req_in,
  // datapath side
  output logic [15:0] shifter_out,
  output logic [7:0] literal_out,
  output logic tick_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // results move every cycle so a stale load never looks right
  initial shifter_out = 16'h0000;
  always @(posedge clk_in) begin
    shifter_out <= shifter_out + 16'h1357;
    literal_out <= shifter_out[15:8];
    tick_out <= tick_req_in;
  end
endmodule : far_datapath_model

// File: bench/test_microsequencer_nanocode_control.sv
module test_microsequencer_nanocode_control;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // stimulus, expectations and monitor
  // ****************************************
  logic clk, rst_b, nvalid, wr, rd, rd_d, tick_req, tick, fetch, lv, ci, mil, b1, b2, ssc;
  logic [1:0] lk, sk, asel;
  logic [55:1] word, prev;
  logic [7:0] addr, dyn, literal_reg;
  logic [31:0] wdata, rdata;
  logic [15:0] shf;
  logic [11:0] maddr, mpc, amp, nxt, la;
  logic [2:0] cadj, acc;
  logic [3:0] mreq, af, os, sa, shift_amount_reg;
  logic [18:0] slot_q[$];  // expected {address, adjust, request}
  logic [23:0] p3e_q[$];   // expected phase-3 levels, pulses and shift amount
  logic [31:0] rd_q[$];
  int error_cnt, num_checks, seed;
  microsequencer_nanocode_control dut (.core_clk_in(clk), .rst_b_in(rst_b),
    .nano_word_in(word), .nano_valid_in(nvalid), .lit_op_valid_in(lv),
    .lit_op_kind_in(lk), .lit_value_in(la), .dyn_cond_in(dyn),
    .literal_reg_in(literal_reg), .shifter_in(shf), .timer_tick_in(tick), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .micro_addr_out(maddr), .fetch_out(fetch), .cond_adjust_out(cadj),
    .mem_req_out(mreq), .carry_inhibit_out(ci), .adder_func_out(af), .shift_kind_out(sk),
    .shift_amount_out(sa), .accum_load_out(acc), .operand_src_out(os),
    .memory_info_load_out(mil), .base_one_load_out(b1), .base_two_load_out(b2),
    .address_sel_out(asel), .sign_save_out(ssc));
  far_datapath_model far (.clk_in(clk), .tick_req_in(tick_req), .shifter_out(shf),
    .literal_out(literal_reg), .tick_out(tick));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim();
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim
  // one strobe cycle; read data is due in the next cycle only
  task automatic reg_access(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    if (!w) rd_q.push_back(d);
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : reg_access
  // one phase-1 slot; c is the condition outcome worked out by the bench
  task automatic slot(input logic [3:0] sel, input logic [2:0] adj, input logic [2:0] st,
      input logic [2:0] sf, input logic gate, input logic c);
    logic [55:1] w;
    logic [2:0] s;
    logic [7:0] d;
    d = 8'($random(seed));
    w = '0;
    // random phase-3 fields; shifter loads of the alternate counter and the shift amount stay off
    w[55:17] = 39'({$random(seed), $random(seed)});
    w[50] = 1'b0;
    w[42] = 1'b0;
    // datapath conditions: outcome and sense worked out here
    if (sel[3]) begin
      w[5] = d[7];
      c = d[sel[2:0]] ^ d[7];
    end
    s = c ? st : sf;
    w[4:1] = sel;
    w[7] = gate;
    w[10:8] = adj;
    w[13:11] = st;
    w[16:14] = sf;
    // held word drives the pulses and the shift amount step
    if (prev[49]) shift_amount_reg = ~shift_amount_reg;
    p3e_q.push_back({w[33:27], prev[41:34], prev[44:43], prev[46:45], prev[55], shift_amount_reg});
    prev = w;
    case (s)
      3'h0: nxt = mpc + 12'h001;
      3'h1: nxt = mpc + 12'h002;
      3'h4: nxt = amp + 12'h002;
      3'h5: nxt = mpc;
      default: nxt = amp + 12'h001;  // call and jump
    endcase
    if (s == 3'h2) amp = mpc;
    mpc = nxt;
    @(posedge clk);
    word <= w;
    nvalid <= 1'b1;
    dyn <= d;
    // a gated-off adjust and request must both read zero
    slot_q.push_back({nxt, (gate && !c) ? 7'h00 : {adj, w[54:51]}});
    @(posedge clk);
    nvalid <= 1'b0;
    @(posedge clk);
  endtask : slot
  // literal-form slot: phase 3 extended, no request or adjust
  task automatic lit_slot(input logic [1:0] k, input logic [11:0] v);
    nxt = (k == 2'h1 || k == 2'h2) ? v + 12'h001 : mpc + 12'h001;
    if (k == 2'h1) amp = mpc;
    mpc = nxt;
    @(posedge clk);
    lv <= 1'b1;
    lk <= k;
    la <= v;
    slot_q.push_back({nxt, 7'h00});
    p3e_q.push_back({prev[33:27], 13'h0000, shift_amount_reg});
    @(posedge clk);
    lv <= 1'b0;
    @(posedge clk);
  endtask : lit_slot
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d === 1'b1) chk(rdata, rd_q.pop_front());
    if (fetch === 1'b1) chk({maddr, cadj, mreq}, slot_q.pop_front());
    if (fetch === 1'b1)
      chk({sk, af, ci, mil, os, acc, b2, b1, asel, ssc, sa}, p3e_q.pop_front());
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #200000;
    error_cnt++;
    end_sim();
  end
  initial begin
    {rst_b, nvalid, wr, rd, tick_req, word, addr, wdata, dyn, lv, lk, la} = '0;
    {error_cnt, num_checks, mpc, amp, prev, shift_amount_reg} = '0;
    seed = 32'hbf9c51dd;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    reg_access(1'b0, micro_ctrl_pkg::REG_CTRL, 32'h00000001);
    reg_access(1'b0, 8'h10, 32'h00000000);
    reg_access(1'b1, micro_ctrl_pkg::REG_CTRL, 32'h00000000);
    slot(4'h0, 3'h0, 3'h0, 3'h5, 1'b0, 1'b1);
    slot(4'h0, 3'h0, 3'h1, 3'h0, 1'b0, 1'b1);
    slot(4'h0, 3'h0, 3'h5, 3'h0, 1'b0, 1'b1);
    slot(4'h0, 3'h0, 3'h2, 3'h0, 1'b0, 1'b1);
    slot(4'h0, 3'h0, 3'h4, 3'h0, 1'b0, 1'b1);
    slot(4'h0, 3'h0, 3'h3, 3'h0, 1'b0, 1'b1);
    slot(4'h0, 3'h1, 3'h0, 3'h0, 1'b0, 1'b1);
    slot(4'h1, 3'h0, 3'h1, 3'h0, 1'b0, 1'b1);
    slot(4'h1, 3'h0, 3'h1, 3'h0, 1'b0, 1'b0);
    slot(4'h1, 3'h1, 3'h0, 3'h5, 1'b1, 1'b0);
    slot(4'h0, 3'h4, 3'h0, 3'h0, 1'b0, 1'b1);
    slot(4'h4, 3'h0, 3'h1, 3'h0, 1'b0, 1'b1);
    slot(4'h4, 3'h0, 3'h1, 3'h0, 1'b0, 1'b1);
    slot(4'h0, 3'h6, 3'h0, 3'h0, 1'b0, 1'b1);
    slot(4'h4, 3'h0, 3'h1, 3'h0, 1'b0, 1'b0);
    tick_req <= 1'b1;
    @(posedge clk);
    tick_req <= 1'b0;
    repeat (6) @(posedge clk);
    slot(4'h6, 3'h0, 3'h1, 3'h0, 1'b0, 1'b1);
    slot(4'h6, 3'h0, 3'h1, 3'h0, 1'b0, 1'b0);
    slot(4'h8, 3'h0, 3'h1, 3'h0, 1'b0, 1'b0);
    slot(4'hd, 3'h0, 3'h1, 3'h5, 1'b0, 1'b0);
    lit_slot(2'h1, 12'h2a0);
    lit_slot(2'h2, 12'h0f0);
    lit_slot(2'h0, 12'h3c3);
    slot(4'h0, 3'h0, 3'h4, 3'h0, 1'b0, 1'b1);
    reg_access(1'b0, micro_ctrl_pkg::REG_SEQ, {4'h0, amp, 4'h0, mpc});
    repeat (4) @(posedge clk);
    end_sim();
  end
endmodule : test_microsequencer_nanocode_control

// File: logic/micro_ctrl_pkg.sv
package micro_ctrl_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W = 12;  // microprogram address width
  localparam int DATA_W = 16;  // datapath word width
  localparam int CTR_W = 8;    // loop counter width
  localparam int SAR_W = 4;    // shift amount width, covers 16 bit positions

  // ****************************************
  // control word field positions (low bit of each field)
  // ****************************************
  localparam int P_CSEL = 1;     // condition select, 4 bits
  localparam int P_SENSE = 5;    // test the complement when set
  localparam int P_LUMOD = 6;    // new datapath operation is conditional
  localparam int P_EXMOD = 7;    // request and adjust are conditional
  localparam int P_CADJ = 8;     // condition adjust, 3 bits
  localparam int P_STRUE = 11;   // true successor, 3 bits
  localparam int P_SFALSE = 14;  // false successor, 3 bits
  localparam int P_P3LO = 17;    // first bit held for phase 3
  localparam int P_CINH = 27;    // carry inhibit between bytes
  localparam int P_AFUNC = 28;   // adder function, 4 bits
  localparam int P_SHIFT = 32;   // shift kind, 2 bits
  localparam int P_ACC = 34;     // accumulator load enables, 3 bits
  localparam int P_BSRC = 37;    // secondary operand source, 4 bits
  localparam int P_MIR = 41;     // memory info reg load
  localparam int P_ALT = 42;     // alternate counter load
  localparam int P_BASE1 = 43;   // base reg one load
  localparam int P_BASE2 = 44;   // base reg two load
  localparam int P_MAR = 45;     // memory address select, 2 bits
  localparam int P_CTRSEL = 46;  // loop counter select, 3 bits (46 shared)
  localparam int P_SARSEL = 49;  // shift amount select, 2 bits
  localparam int P_MREQ = 51;    // memory/device request, 4 bits
  localparam int P_SSC = 55;     // sign save control

  // ****************************************
  // successor operations
  // ****************************************
  typedef enum logic [2:0] {
    SUCC_STEP = 3'h0,
    SUCC_SKIP = 3'h1,
    SUCC_CALL = 3'h2,
    SUCC_JUMP = 3'h3,
    SUCC_RETURN = 3'h4,
    SUCC_WAIT = 3'h5,
    SUCC_EXEC = 3'h6,
    SUCC_SAVE = 3'h7
  } succ_t;

  // literal-form microinstruction kinds
  localparam logic [1:0] LIT_CALL = 2'h1;  // literal_call_op
  localparam logic [1:0] LIT_MARK = 2'h2;

  // condition adjust codes: 1..3 set local, 4..5 set global, 6..7 reset global
  localparam logic [2:0] CADJ_SET_L1 = 3'h1;
  localparam logic [2:0] CADJ_SET_G1 = 3'h4;
  localparam logic [2:0] CADJ_RST_G1 = 3'h6;

  // condition select indices
  localparam logic [3:0] CSEL_L1 = 4'h1;
  localparam logic [3:0] CSEL_G1 = 4'h4;
  localparam logic [3:0] CSEL_TIMER = 4'h6;

  // shift kinds
  localparam logic [1:0] SHIFT_RIGHT = 2'h1;
  localparam logic [1:0] SHIFT_LEFT = 2'h2;
  localparam logic [1:0] SHIFT_CIRC = 2'h3;

  // loop counter and shift amount selections
  localparam logic [2:0] CTR_LOAD_INV = 3'h1;
  localparam logic [2:0] CTR_LOAD_SHF = 3'h2;
  localparam logic [2:0] CTR_INC = 3'h3;
  localparam logic [1:0] SAR_COMP = 2'h1;
  localparam logic [1:0] SAR_LOAD = 2'h2;

  // ****************************************
  // register map and reset values
  // ****************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_FLAGS = 8'h04;
  localparam logic [7:0] REG_SEQ = 8'h08;
  localparam logic [7:0] REG_CNT = 8'h0c;
  localparam logic RST_HALT = 1'b1;
  localparam logic [11:0] RST_ADDR = 12'h000;

endpackage : micro_ctrl_pkg

// File: logic/microsequencer_nanocode_control.sv
// Notes on behaviour
// - bit 6 gates loading new phase-3 operation
// - bit 7 gates request and condition adjust
// - bits 11-16 pick true/false successor
// - issue adjust 8-10 and request 51-54
// - bit 27 blocks carry between bytes
// - bits 28-31 select adder function
// - bits 32-33 select shift, distance from SHIFT_AMOUNT_REG
// - bits 34-36 load the three accumulators
// - bits 37-40 choose secondary operand source
// - bits 41-44 load info, alternate, base regs
// - bits 46-48 steer loop counter
// - bits 49-50 complement or load shift amount
// - call: alternate plus one, swap counters
// - jump: alternate plus one into counter
// - return: alternate plus two into counter
// - literal call: literal plus one, save counter
// - local flags set by microcode, cleared by test
// - global flags survive test, explicit reset only
// - timer flag set outside, cleared by test
// - increment counter, overflow sets flag
// - load counter inverted literal, clear overflow
// - shifter: left, right end-off, right circular
// - step: counter plus one
// - skip: counter plus two
// - wait: refetch, both counters unchanged
//
// Implementation choices: the address map and the strobed register port.
module microsequencer_nanocode_control #(
  parameter int ADDR_W = micro_ctrl_pkg::ADDR_W,
  parameter int CTR_W = micro_ctrl_pkg::CTR_W,
  parameter int SAR_W = micro_ctrl_pkg::SAR_W
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // control word, one per phase-1 strobe
  input wire logic [55:1] nano_word_in,
  input wire logic nano_valid_in,
  // literal-form microinstruction
  input wire logic lit_op_valid_in,
  input wire logic [1:0] lit_op_kind_in,
  input wire logic [ADDR_W-1:0] lit_value_in,
  // datapath inputs
  input wire logic [7:0] dyn_cond_in,
  input wire logic [CTR_W-1:0] literal_reg_in,
  input wire logic [15:0] shifter_in,
  // external timing source, asynchronous
  input wire logic timer_tick_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // sequencer outputs
  output logic [ADDR_W-1:0] micro_addr_out,
  output logic fetch_out,
  output logic [2:0] cond_adjust_out,
  output logic [3:0] mem_req_out,
  // phase-3 controls
  output logic carry_inhibit_out,
  output logic [3:0] adder_func_out,
  output logic [1:0] shift_kind_out,
  output logic [SAR_W-1:0] shift_amount_out,
  // end-of-phase-3 load enables
  output logic [2:0] accum_load_out,
  output logic [3:0] operand_src_out,
  output logic memory_info_load_out,
  output logic base_one_load_out,
  output logic base_two_load_out,
  output logic [1:0] address_sel_out,
  output logic sign_save_out
);

  // ****************************************
  // reset release and pin synchroniser
  // ****************************************
  logic [1:0] rst_sync_q;  // release path for the async reset
  logic rst_n;             // synchronised reset, active low
  logic tick_meta_q;       // first stage, read only by tick_sync_q
  logic tick_sync_q;
  logic tick_prev_q;       // for rising-edge detection

  // async assert, synchronous release
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // timer pin passes two flops before use
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      tick_meta_q <= 1'b0;
      tick_sync_q <= 1'b0;
      tick_prev_q <= 1'b0;
    end else begin
      tick_meta_q <= timer_tick_in;
      tick_sync_q <= tick_meta_q;
      tick_prev_q <= tick_sync_q;
    end
  end

  // ****************************************
  // state
  // ****************************************
  logic halt_q;                       // software stop of the sequencer
  logic [ADDR_W-1:0] mpc_q, mpc_d;    // microprogram_counter
  logic [ADDR_W-1:0] amp_q, amp_d;    // alternate_return_counter
  logic [ADDR_W-1:0] seq_addr;        // address fetched next
  localparam int P_P3LO_W = micro_ctrl_pkg::P_P3LO;  // low end of the held word
  logic [55:P_P3LO_W] p3_q;           // held phase-3 part of the word
  logic [2:0] lflag_q;                // local_flag_one..three
  logic [1:0] gflag_q;                // global_flag_one..two
  logic timer_q;                      // timer_tick_flag
  logic cov_q;                        // counter_overflow_flag
  logic [CTR_W-1:0] ctr_q;            // loop_counter
  logic [SAR_W-1:0] sar_q;            // shift_amount_reg

  // ****************************************
  // phase-1 decode
  // ****************************************
  wire [3:0] cond_sel = nano_word_in[micro_ctrl_pkg::P_CSEL +: 4];
  wire [15:0] cond_vec = {dyn_cond_in, cov_q, timer_q, gflag_q, lflag_q, 1'b1};
  // bit 5 set means the false sense is tested
  wire cond_met = cond_vec[cond_sel] ^ nano_word_in[micro_ctrl_pkg::P_SENSE];
  wire lit_go = lit_op_valid_in & ~halt_q;
  // literal form takes the slot; its datapath part stays extended
  wire instr_go = nano_valid_in & ~halt_q & ~lit_go;
  wire luop_go = instr_go & (~nano_word_in[micro_ctrl_pkg::P_LUMOD] | cond_met);
  wire extop_go = instr_go & (~nano_word_in[micro_ctrl_pkg::P_EXMOD] | cond_met);
  wire [2:0] adj_code = extop_go ? nano_word_in[micro_ctrl_pkg::P_CADJ +: 3] : 3'h0;
  wire [3:0] req_code = extop_go ? nano_word_in[micro_ctrl_pkg::P_MREQ +: 4] : 4'h0;
  // successor chosen by the condition outcome
  wire [2:0] succ = cond_met ? nano_word_in[micro_ctrl_pkg::P_STRUE +: 3]
                             : nano_word_in[micro_ctrl_pkg::P_SFALSE +: 3];

  // ****************************************
  // held phase-3 destination fields
  // ****************************************
  wire [2:0] p3_acc = p3_q[micro_ctrl_pkg::P_ACC +: 3];
  wire [2:0] p3_ctrsel = p3_q[micro_ctrl_pkg::P_CTRSEL +: 3];
  wire [1:0] p3_sarsel = p3_q[micro_ctrl_pkg::P_SARSEL +: 2];
  wire p3_alt = p3_q[micro_ctrl_pkg::P_ALT];
  wire [CTR_W:0] ctr_inc = {1'b0, ctr_q} + {{CTR_W{1'b0}}, 1'b1};

  // true when a test of condition index idx is under way
  function automatic logic tested(input logic go, input logic [3:0] sel,
                                  input logic [3:0] idx);
    tested = go & (sel == idx);
  endfunction : tested

  // ****************************************
  // condition flags
  // ****************************************
  // a set in the same cycle as the clearing test wins
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_local
      wire set_l = (adj_code == micro_ctrl_pkg::CADJ_SET_L1 + 3'(gi));
      wire clr_l = tested(instr_go, cond_sel, micro_ctrl_pkg::CSEL_L1 + 4'(gi));
      always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          lflag_q[gi] <= 1'b0;
        end else begin
          lflag_q[gi] <= set_l | (lflag_q[gi] & ~clr_l);
        end
      end
    end
    for (gi = 0; gi < 2; gi++) begin : g_global
      wire set_g = (adj_code == micro_ctrl_pkg::CADJ_SET_G1 + 3'(gi));
      wire rst_g = (adj_code == micro_ctrl_pkg::CADJ_RST_G1 + 3'(gi));
      // testing leaves these alone
      always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
          gflag_q[gi] <= 1'b0;
        end else begin
          gflag_q[gi] <= set_g | (gflag_q[gi] & ~rst_g);
        end
      end
    end
  endgenerate

  // timer flag: outside edge sets, test clears, edge wins
  wire tick_rise = tick_sync_q & ~tick_prev_q;
  wire timer_clr = tested(instr_go, cond_sel, micro_ctrl_pkg::CSEL_TIMER);
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= 1'b0;
    end else begin
      timer_q <= tick_rise | (timer_q & ~timer_clr);
    end
  end

  // ****************************************
  // successor logic
  // ****************************************
  always_comb begin
    mpc_d = mpc_q;
    amp_d = amp_q;
    seq_addr = mpc_q;
    // shifter load of the alternate counter at end of phase 3
    if (luop_go && p3_alt) begin
      amp_d = shifter_in[ADDR_W-1:0];
    end
    if (lit_go) begin
      seq_addr = lit_value_in + ADDR_W'(1);
      if (lit_op_kind_in == micro_ctrl_pkg::LIT_CALL) begin
        mpc_d = seq_addr;
        amp_d = mpc_q;
      end else if (lit_op_kind_in == micro_ctrl_pkg::LIT_MARK) begin
        mpc_d = seq_addr;
      end else begin
        seq_addr = mpc_q + ADDR_W'(1);
        mpc_d = seq_addr;
      end
    end else if (instr_go) begin
      // successor writes win over a shifter load of the alternate
      case (succ)
        micro_ctrl_pkg::SUCC_STEP: begin
          seq_addr = mpc_q + ADDR_W'(1);
          mpc_d = seq_addr;
        end
        micro_ctrl_pkg::SUCC_SKIP: begin
          seq_addr = mpc_q + ADDR_W'(2);
          mpc_d = seq_addr;
        end
        micro_ctrl_pkg::SUCC_CALL: begin
          seq_addr = amp_q + ADDR_W'(1);
          mpc_d = seq_addr;
          amp_d = mpc_q;
        end
        micro_ctrl_pkg::SUCC_JUMP: begin
          seq_addr = amp_q + ADDR_W'(1);
          mpc_d = seq_addr;
        end
        micro_ctrl_pkg::SUCC_RETURN: begin
          seq_addr = amp_q + ADDR_W'(2);
          mpc_d = seq_addr;
        end
        micro_ctrl_pkg::SUCC_WAIT: begin
          seq_addr = mpc_q;
          mpc_d = mpc_q;
          amp_d = amp_q;
        end
        micro_ctrl_pkg::SUCC_EXEC: begin
          seq_addr = amp_q + ADDR_W'(1);  // out of line, counter kept
        end
        micro_ctrl_pkg::SUCC_SAVE: begin
          seq_addr = mpc_q + ADDR_W'(2);
          mpc_d = seq_addr;
          amp_d = mpc_q;
        end
        default: begin
          seq_addr = mpc_q;
        end
      endcase
    end
  end

  // sequencer registers and fetch address
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mpc_q <= ADDR_W'(micro_ctrl_pkg::RST_ADDR);
      amp_q <= ADDR_W'(micro_ctrl_pkg::RST_ADDR);
      micro_addr_out <= ADDR_W'(micro_ctrl_pkg::RST_ADDR);
      fetch_out <= 1'b0;
    end else begin
      mpc_q <= mpc_d;
      amp_q <= amp_d;
      micro_addr_out <= (lit_go | instr_go) ? seq_addr : micro_addr_out;
      fetch_out <= lit_go | instr_go;
    end
  end

  // ****************************************
  // end of phase 1: adjust and request pulses
  // ****************************************
  // zero codes come out as zero, so nothing is requested
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cond_adjust_out <= 3'h0;
      mem_req_out <= 4'h0;
    end else begin
      cond_adjust_out <= adj_code;
      mem_req_out <= req_code;
    end
  end

  // ****************************************
  // phase 3: held word and destination pulses
  // ****************************************
  // the held word stays until a new operation is taken, so an
  // untaken operation extends phase 3 with no destination change
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      p3_q <= '0;
      accum_load_out <= 3'h0;
      operand_src_out <= 4'h0;
      memory_info_load_out <= 1'b0;
      base_one_load_out <= 1'b0;
      base_two_load_out <= 1'b0;
      address_sel_out <= 2'h0;
      sign_save_out <= 1'b0;
    end else if (luop_go) begin
      p3_q <= nano_word_in[55:P_P3LO_W];
      accum_load_out <= p3_acc;
      operand_src_out <= p3_q[micro_ctrl_pkg::P_BSRC +: 4];
      memory_info_load_out <= p3_q[micro_ctrl_pkg::P_MIR];
      base_one_load_out <= p3_q[micro_ctrl_pkg::P_BASE1];
      base_two_load_out <= p3_q[micro_ctrl_pkg::P_BASE2];
      address_sel_out <= p3_q[micro_ctrl_pkg::P_MAR +: 2];
      sign_save_out <= p3_q[micro_ctrl_pkg::P_SSC];
    end else begin
      accum_load_out <= 3'h0;
      operand_src_out <= 4'h0;
      memory_info_load_out <= 1'b0;
      base_one_load_out <= 1'b0;
      base_two_load_out <= 1'b0;
      address_sel_out <= 2'h0;
      sign_save_out <= 1'b0;
    end
  end

  // phase-3 controls straight off the held word; shift amount off shift_amount_reg
  assign carry_inhibit_out = p3_q[micro_ctrl_pkg::P_CINH];
  assign adder_func_out = p3_q[micro_ctrl_pkg::P_AFUNC +: 4];
  assign shift_kind_out = p3_q[micro_ctrl_pkg::P_SHIFT +: 2];
  assign shift_amount_out = sar_q;

  // ****************************************
  // loop counter and shift amount
  // ****************************************
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ctr_q <= '0;
      cov_q <= 1'b0;
      sar_q <= '0;
    end else if (luop_go) begin
      case (p3_ctrsel)
        micro_ctrl_pkg::CTR_LOAD_INV: begin
          ctr_q <= ~literal_reg_in;
          cov_q <= 1'b0;
        end
        micro_ctrl_pkg::CTR_LOAD_SHF: begin
          ctr_q <= shifter_in[CTR_W-1:0];
        end
        micro_ctrl_pkg::CTR_INC: begin
          ctr_q <= ctr_inc[CTR_W-1:0];
          cov_q <= cov_q | ctr_inc[CTR_W];
        end
        default: begin
          ctr_q <= ctr_q;
        end
      endcase
      case (p3_sarsel)
        micro_ctrl_pkg::SAR_COMP: sar_q <= ~sar_q;
        micro_ctrl_pkg::SAR_LOAD: sar_q <= shifter_in[SAR_W-1:0];
        default: sar_q <= sar_q;
      endcase
    end
  end

  // ****************************************
  // register port
  // ****************************************
  // halt resets high so software can set up before the first fetch
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      halt_q <= micro_ctrl_pkg::RST_HALT;
    end else if (reg_wr_in && reg_addr_in == micro_ctrl_pkg::REG_CTRL) begin
      halt_q <= reg_wdata_in[0];
    end
  end

  wire [31:0] rd_word =
    (reg_addr_in == micro_ctrl_pkg::REG_CTRL) ? {31'h0, halt_q} :
    (reg_addr_in == micro_ctrl_pkg::REG_FLAGS) ? {25'h0, cov_q, timer_q, gflag_q, lflag_q} :
    (reg_addr_in == micro_ctrl_pkg::REG_SEQ) ? {16'(amp_q), 16'(mpc_q)} :
    (reg_addr_in == micro_ctrl_pkg::REG_CNT) ? {16'h0, 8'(sar_q), 8'(ctr_q)} : 32'h0;

  // read data only in the cycle after the strobe, else zero
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_out <= 32'h0;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_word : 32'h0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  wire w_step = instr_go && succ == micro_ctrl_pkg::SUCC_STEP;
  wire w_call = instr_go && succ == micro_ctrl_pkg::SUCC_CALL;

  property p_luop_hold;
    !luop_go ##1 !luop_go |-> $stable(adder_func_out) && $stable(carry_inhibit_out);
  endproperty
  a_luop_hold: assert property (p_luop_hold) else $error("phase-3 word changed");

  property p_extop_gate;
    instr_go && nano_word_in[micro_ctrl_pkg::P_EXMOD] && !cond_met
      |=> cond_adjust_out == 3'h0 && mem_req_out == 4'h0;
  endproperty
  a_extop_gate: assert property (p_extop_gate) else $error("request leaked");

  property p_req_issue;
    extop_go |=> mem_req_out == $past(nano_word_in[54:51]);
  endproperty
  a_req_issue: assert property (p_req_issue) else $error("request wrong");

  property p_step;
    w_step |=> micro_addr_out == $past(mpc_q) + ADDR_W'(1) && mpc_q == micro_addr_out;
  endproperty
  a_step: assert property (p_step) else $error("step address wrong");

  property p_call;
    w_call |=> micro_addr_out == $past(amp_q) + ADDR_W'(1) && amp_q == $past(mpc_q);
  endproperty
  a_call: assert property (p_call) else $error("call exchange wrong");

  property p_return;
    instr_go && succ == micro_ctrl_pkg::SUCC_RETURN |=> mpc_q == $past(amp_q) + ADDR_W'(2);
  endproperty
  a_return: assert property (p_return) else $error("return wrong");

  property p_wait;
    instr_go && succ == micro_ctrl_pkg::SUCC_WAIT |=> $stable(mpc_q) && $stable(amp_q);
  endproperty
  a_wait: assert property (p_wait) else $error("wait moved counters");

  property p_local_clr;
    instr_go && cond_sel == micro_ctrl_pkg::CSEL_L1 && adj_code != micro_ctrl_pkg::CADJ_SET_L1
      |=> !lflag_q[0];
  endproperty
  a_local_clr: assert property (p_local_clr) else $error("local flag kept");

  property p_global_keep;
    instr_go && cond_sel == micro_ctrl_pkg::CSEL_G1 && adj_code == 3'h0 |=> $stable(gflag_q);
  endproperty
  a_global_keep: assert property (p_global_keep) else $error("global flag moved");

  property p_inc;
    luop_go && p3_ctrsel == micro_ctrl_pkg::CTR_INC |=> ctr_q == $past(ctr_q) + CTR_W'(1);
  endproperty
  a_inc: assert property (p_inc) else $error("counter not incremented");

  property p_load_counter_inverted;
    luop_go && p3_ctrsel == micro_ctrl_pkg::CTR_LOAD_INV
      |=> ctr_q == ~$past(literal_reg_in) && !cov_q;
  endproperty
  a_load_counter_inverted: assert property (p_load_counter_inverted) else $error("inverted load wrong");

  property p_dest;
    luop_go |=> accum_load_out == $past(p3_acc);
  endproperty
  a_dest: assert property (p_dest) else $error("accumulator enables wrong");

  c_call_return: cover property (w_call ##[1:20] instr_go && succ == micro_ctrl_pkg::SUCC_RETURN);
  c_overflow: cover property (luop_go && p3_ctrsel == micro_ctrl_pkg::CTR_INC && ctr_inc[CTR_W]);
  c_timer: cover property (timer_q ##1 timer_clr);

endmodule : microsequencer_nanocode_control
